//--- tb_top.sv
// self-checking bench for the timer unit
`timescale 1ns/1ps
`include "tcp_defines.vh"
module tb_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg ext_run = 1'b0, gate_req = 1'b0, rst_req = 1'b0;
   reg cap_req = 1'b0, kill_req = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, ext_clk_in, gate_en, timer_rst, capture_in, kill;
   wire compare_out, compare_n_out, tc_out, pwm_hi, pwm_lo, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg [33:0] exp_r[$];
   reg [1:0] exp_b[$];
   integer err_total = 0, checks_done = 0, seed = 99830;
   integer i, j, ni, nt;
   reg tp, e, ta, tw;
   reg [15:0] pv;
   tcp_top #(.FIXDIV(4)) dut (.*);
   tcp_fabric fab (.*);
   always #5 aclk = !aclk;
   task cmp_bus(input [33:0] got, input [33:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t bus got %h want %h", $time, got, exp);
         end
      end
   endtask
   task cmp_pin(input got, input exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t pin check %0d", $time, checks_done);
         end
      end
   endtask
   // results are compared in arrival order against the noted expectations
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         cmp_bus({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         cmp_bus({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
   end
   task wait_hi(input integer sel);
      begin
         #1;
         while (!(sel ? s_axi_rvalid : s_axi_bvalid)) begin
            @(posedge aclk);
            #1;
         end
      end
   endtask
   task rd(input [7:0] a, input [33:0] ex);
      begin
         exp_r.push_back(ex);
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         #1;
         while (!s_axi_arready) begin
            @(posedge aclk);
            #1;
         end
         @(posedge aclk);
         s_axi_arvalid <= 1'b0;
         wait_hi(1);
         @(posedge aclk);
         s_axi_rready <= 1'b1;
         @(posedge aclk);
         s_axi_rready <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] ex);
      begin
         exp_b.push_back(ex);
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         ta = 0;
         tw = 0;
         while (!(ta && tw)) begin
            #1;
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
         end
         wait_hi(0);
         @(posedge aclk);
         s_axi_bready <= 1'b1;
         @(posedge aclk);
         s_axi_bready <= 1'b0;
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      #500000;
      err_total = err_total + 1;
      stop_test;
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`TCP_OFS_CTRL, 34'h0);
      rd(`TCP_OFS_PERIOD, 34'hFFFF);
      rd(`TCP_OFS_COMPARE, 34'h8000);
      rd(`TCP_OFS_COUNT, 34'hFFFF);
      rd(`TCP_OFS_CAPTURE, 34'h0);
      rd(8'h20, {`TCP_RESP_SLVERR, 32'h0});
      wr(8'h24, 32'h1, `TCP_RESP_SLVERR);
      // every clock source: period 4 ticks, irq on terminal count
      wr(`TCP_OFS_PERIOD, 32'h3, 2'h0);
      wr(`TCP_OFS_PRESCALE, 32'h1, 2'h0);
      ext_run <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         wr(`TCP_OFS_CTRL, 32'h101 | (i << 6), 2'h0);
         ni = 0;
         nt = 0;
         tp = 0;
         repeat (400) begin
            @(posedge aclk);
            #1;
            ni = ni + irq;
            nt = nt + (tc_out && !tp);
            tp = tc_out;
         end
         wr(`TCP_OFS_CTRL, 32'h0, 2'h0);
         j = 100 / (i == 0 ? 1 : i == 1 ? 4 : i == 2 ? 2 : 10);
         cmp_pin(ni >= j - 1 && ni <= j + 1, 1'b1);
         cmp_pin(nt >= j - 1 && nt <= j + 1, 1'b1);
      end
      pv = 16'h0010 | ($random(seed) & 16'h007F);
      wr(`TCP_OFS_PERIOD, {16'h0, pv}, 2'h0);
      wr(`TCP_OFS_CTRL, 32'h003, 2'h0);
      repeat (300) @(posedge aclk);
      rd(`TCP_OFS_CTRL, 34'h002);
      rd(`TCP_OFS_COUNT, {18'h0, pv});
      pv = 16'h1000 | ($random(seed) & 16'h0FFF);
      wr(`TCP_OFS_PERIOD, {16'h0, pv}, 2'h0);
      wr(`TCP_OFS_CTRL, 32'h405, 2'h0);
      repeat (20) @(posedge aclk);
      rd(`TCP_OFS_COUNT, {18'h0, pv});
      gate_req <= 1'b1;
      repeat (30) @(posedge aclk);
      gate_req <= 1'b0;
      rst_req <= 1'b1;
      @(posedge aclk);
      rst_req <= 1'b0;
      cap_req <= 1'b1;
      @(posedge aclk);
      cap_req <= 1'b0;
      // capture irq follows the captured edge by one cycle
      @(posedge aclk);
      #1;
      cmp_pin(irq, 1'b1);
      rd(`TCP_OFS_COUNT, {18'h0, pv});
      rd(`TCP_OFS_CAPTURE, {18'h0, pv});
      // counter holds pv; compare one below, equal and one above
      for (i = 0; i < 5; i = i + 1)
         for (j = -1; j < 2; j = j + 1) begin
            wr(`TCP_OFS_COMPARE, pv + j, 2'h0);
            wr(`TCP_OFS_CTRL, 32'h805 | (i << 3), 2'h0);
            e = i == 0 ? j > 0 : i == 1 ? j >= 0 : i == 2 ? j == 0 :
               i == 3 ? j <= 0 : j < 0;
            rd(`TCP_OFS_STATUS, {31'h0, e, 2'h1});
            #1;
            cmp_pin(compare_out, e);
            cmp_pin(compare_n_out, !e);
         end
      wr(`TCP_OFS_CTRL, 32'h0, 2'h0);
      wr(`TCP_OFS_DEADBAND, 32'h4, 2'h0);
      wr(`TCP_OFS_PERIOD, 32'hF, 2'h0);
      wr(`TCP_OFS_COMPARE, 32'h8, 2'h0);
      wr(`TCP_OFS_CTRL, 32'h201, 2'h0);
      ni = 0;
      nt = 999;
      j = 0;
      repeat (200) begin
         @(posedge aclk);
         #1;
         j = j + irq;
         if (!pwm_hi && !pwm_lo) ni = ni + 1;
         else begin
            if (ni > 0 && ni < nt) nt = ni;
            ni = 0;
         end
      end
      cmp_pin(nt >= 4 && nt < 999, 1'b1);
      // compare turns true once per 16-count period
      cmp_pin(j >= 11 && j <= 14, 1'b1);
      kill_req <= 1'b1;
      repeat (3) @(posedge aclk);
      #1;
      cmp_pin(compare_out | pwm_hi | pwm_lo, 1'b0);
      kill_req <= 1'b0;
      stop_test;
   end
endmodule // tb_top

//--- tcp_clk_sel.v
// count-clock source selection: one-cycle tick enables from several sources
`timescale 1ns/1ps
`include "tcp_defines.vh"
module tcp_clk_sel #(
   parameter FIXDIV = `TCP_FIXDIV
) (
   input wire aclk,
   input wire aresetn,
   input wire [1:0] sel,
   input wire [15:0] prescale,
   input wire ext_clk_in,
   output reg tick
);
   reg [15:0] fix_q;
   reg [15:0] pre_q;
   reg ext_q;
   wire fix_hit;
   wire pre_hit;

   assign fix_hit = (fix_q == FIXDIV[15:0] - 16'h0001);
   assign pre_hit = (pre_q >= prescale);

   always @(posedge aclk) begin
      if (!aresetn) begin
         fix_q <= 16'h0000;
         pre_q <= 16'h0000;
         ext_q <= 1'b0;
      end else begin
         fix_q <= fix_hit ? 16'h0000 : fix_q + 16'h0001;
         pre_q <= pre_hit ? 16'h0000 : pre_q + 16'h0001;
         ext_q <= ext_clk_in;
      end
   end

   // tick is high every cycle for the bus source, for a prescale of 0 or for an FIXDIV of 1, and one aclk cycle wide otherwise
   always @* begin
      case (sel)
         `TCP_CSEL_BUS: tick = 1'b1;
         `TCP_CSEL_FIXDIV: tick = fix_hit;
         `TCP_CSEL_PRESCALE: tick = pre_hit;
         `TCP_CSEL_EXT: tick = ext_clk_in & ~ext_q;
         default: tick = 1'b0;
      endcase
   end
endmodule // tcp_clk_sel

//--- tcp_deadband.v
// complementary output pair with deadband and kill
`timescale 1ns/1ps
module tcp_deadband #(
   parameter DBW = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire tick,
   input wire level_in,
   input wire kill,
   input wire [DBW-1:0] dead,
   output reg out_hi,
   output reg out_lo
);
   reg lvl_q;
   reg [DBW-1:0] gap_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q <= 1'b0;
         gap_q <= {DBW{1'b0}};
         out_hi <= 1'b0;
         out_lo <= 1'b0;
      end else begin
         if (level_in != lvl_q) begin
            // every edge restarts the gap in count-clock ticks
            lvl_q <= level_in;
            gap_q <= dead;
         end else if (tick && gap_q != {DBW{1'b0}}) begin
            gap_q <= gap_q - {{(DBW-1){1'b0}}, 1'b1};
         end
         out_hi <= lvl_q & (gap_q == {DBW{1'b0}}) & ~kill;
         out_lo <= ~lvl_q & (gap_q == {DBW{1'b0}}) & ~kill;
      end
   end
endmodule // tcp_deadband

//--- tcp_defines.vh
// register map, field positions, reset values and encodings of the timer unit
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH

`define TCP_OFS_CTRL 8'h00
`define TCP_OFS_PERIOD 8'h04
`define TCP_OFS_COMPARE 8'h08
`define TCP_OFS_COUNT 8'h0C
`define TCP_OFS_CAPTURE 8'h10
`define TCP_OFS_DEADBAND 8'h14
`define TCP_OFS_STATUS 8'h18
`define TCP_OFS_PRESCALE 8'h1C

`define TCP_CTRL_EN 0
`define TCP_CTRL_MODE_LO 1
`define TCP_CTRL_MODE_HI 2
`define TCP_CTRL_REL_LO 3
`define TCP_CTRL_REL_HI 5
`define TCP_CTRL_CSEL_LO 6
`define TCP_CTRL_CSEL_HI 7
`define TCP_CTRL_IE_TC 8
`define TCP_CTRL_IE_CMP 9
`define TCP_CTRL_IE_CAP 10
`define TCP_CTRL_CMPN_EN 11
`define TCP_CTRL_BITS 12

`define TCP_MODE_FREE 2'h0
`define TCP_MODE_ONESHOT 2'h1
`define TCP_MODE_GATED 2'h2

`define TCP_REL_LESS 3'h0
`define TCP_REL_LESS_OR_SAME 3'h1
`define TCP_REL_SAME 3'h2
`define TCP_REL_GREATER_OR_SAME 3'h3
`define TCP_REL_GREATER 3'h4

`define TCP_CSEL_BUS 2'h0
`define TCP_CSEL_FIXDIV 2'h1
`define TCP_CSEL_PRESCALE 2'h2
`define TCP_CSEL_EXT 2'h3

`define TCP_RST_CTRL 12'h000
`define TCP_RST_PERIOD 16'hFFFF
`define TCP_RST_COMPARE 16'h8000
`define TCP_RST_DEADBAND 8'h00
`define TCP_RST_PRESCALE 16'h0000
`define TCP_FIXDIV 16

`define TCP_RESP_OKAY 2'h0
`define TCP_RESP_SLVERR 2'h2

`endif

//--- tcp_fabric.sv
// model of the routing fabric feeding the timer's control inputs
`timescale 1ns/1ps
module tcp_fabric #(
   parameter EXT_HALF = 5
) (
   input wire aclk,
   input wire ext_run,
   input wire gate_req,
   input wire rst_req,
   input wire cap_req,
   input wire kill_req,
   output reg ext_clk_in,
   output reg gate_en,
   output reg timer_rst,
   output reg capture_in,
   output reg kill
);
   reg [7:0] div_q;
   // external count source stands still while not in use
   always @(posedge aclk) begin
      if (!ext_run) begin
         div_q <= 8'h00;
         ext_clk_in <= 1'b0;
      end else if (div_q == EXT_HALF - 1) begin
         div_q <= 8'h00;
         ext_clk_in <= !ext_clk_in;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   // routed signals pass one pipeline stage, as a synchronised route does
   always @(posedge aclk) begin
      gate_en <= gate_req;
      timer_rst <= rst_req;
      capture_in <= cap_req;
      kill <= kill_req;
   end
endmodule // tcp_fabric

//--- tcp_top.v
// 16-bit down-counting timer/counter/pwm with an axi4-lite register slave
// Function
// - counter is 16 bits wide and only counts downward.
// - count clock is chosen from several sources by configuration.
// - compare, terminal count, optional inverted compare and one interrupt line.
// - modes: free running, one shot, or enable-input controlled.
// - in gated mode count only while enable input is high, else hold.
// - one-shot mode stops at end of period instead of continuing.
// - period loads on start, on reset input and at terminal count.
// - timer reset and capture inputs come from the routing fabric.
// - capture stores the whole 16-bit count in a readable register.
// - comparator relation selectable: less, less-or-same, same, greater-or-same, greater.
// - interrupt from terminal count, compare true or capture, each selectable.
// - complementary pwm pair separated by a deadband with both outputs off.
// - kill input forces comparator-derived outputs inactive while asserted.
`timescale 1ns/1ps
`include "tcp_defines.vh"
module tcp_top #(
   parameter WIDTH = 16,
   parameter DBW = 8,
   parameter FIXDIV = `TCP_FIXDIV
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire ext_clk_in,
   input wire gate_en,
   input wire timer_rst,
   input wire capture_in,
   input wire kill,
   output reg compare_out,
   output reg compare_n_out,
   output reg tc_out,
   output wire pwm_hi,
   output wire pwm_lo,
   output reg irq
);
   // register file
   reg [`TCP_CTRL_BITS-1:0] ctrl_q;
   reg [WIDTH-1:0] period_q;
   reg [WIDTH-1:0] compare_q;
   reg [WIDTH-1:0] capture_q;
   reg [DBW-1:0] dead_q;
   reg [15:0] prescale_q;

   // axi state
   reg aw_full_q;
   reg w_full_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   // counter state
   reg [WIDTH-1:0] cnt_q;
   reg run_q;
   reg cap_q;
   reg cmp_q;

   wire tick;
   wire [1:0] mode;
   wire [2:0] rel;
   wire wr_go;
   wire wr_ctrl;
   wire start;
   wire active;
   wire at_zero;
   wire tc_evt;
   wire cap_evt;
   reg cmp_raw;
   reg [31:0] rd_mux;
   reg rd_hit;
   reg [31:0] wmask;
   reg wr_hit;
   integer i;

   assign mode = ctrl_q[`TCP_CTRL_MODE_HI:`TCP_CTRL_MODE_LO];
   assign rel = ctrl_q[`TCP_CTRL_REL_HI:`TCP_CTRL_REL_LO];

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = ~aw_full_q & ~bvalid_q;
   assign s_axi_wready = ~w_full_q & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
   assign wr_ctrl = wr_go && {awaddr_q[7:2], 2'b00} == `TCP_OFS_CTRL
      && wstrb_q[0];
   // a write that sets the enable bit while stopped starts a period
   assign start = wr_ctrl & wdata_q[`TCP_CTRL_EN] & ~run_q;

   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         wmask[i*8 +: 8] = {8{wstrb_q[i]}};
      end
      case ({awaddr_q[7:2], 2'b00})
         `TCP_OFS_CTRL, `TCP_OFS_PERIOD, `TCP_OFS_COMPARE, `TCP_OFS_COUNT,
         `TCP_OFS_CAPTURE, `TCP_OFS_DEADBAND, `TCP_OFS_STATUS,
         `TCP_OFS_PRESCALE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `TCP_RESP_OKAY;
         ctrl_q <= `TCP_RST_CTRL;
         period_q <= `TCP_RST_PERIOD;
         compare_q <= `TCP_RST_COMPARE;
         dead_q <= `TCP_RST_DEADBAND;
         prescale_q <= `TCP_RST_PRESCALE;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
            case ({awaddr_q[7:2], 2'b00})
               `TCP_OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask[`TCP_CTRL_BITS-1:0])
                  | (wdata_q[`TCP_CTRL_BITS-1:0] & wmask[`TCP_CTRL_BITS-1:0]);
               `TCP_OFS_PERIOD: period_q <= (period_q & ~wmask[WIDTH-1:0])
                  | (wdata_q[WIDTH-1:0] & wmask[WIDTH-1:0]);
               `TCP_OFS_COMPARE: compare_q <= (compare_q & ~wmask[WIDTH-1:0])
                  | (wdata_q[WIDTH-1:0] & wmask[WIDTH-1:0]);
               `TCP_OFS_DEADBAND: dead_q <= (dead_q & ~wmask[DBW-1:0])
                  | (wdata_q[DBW-1:0] & wmask[DBW-1:0]);
               `TCP_OFS_PRESCALE: prescale_q <= (prescale_q & ~wmask[15:0])
                  | (wdata_q[15:0] & wmask[15:0]);
               default: ;
            endcase
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         // a finished one shot drops the enable bit so the control register reads stopped
         if (active && at_zero && mode == `TCP_MODE_ONESHOT && !wr_ctrl) begin
            ctrl_q[`TCP_CTRL_EN] <= 1'b0;
         end
      end
   end

   always @* begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
         `TCP_OFS_CTRL: rd_mux[`TCP_CTRL_BITS-1:0] = ctrl_q;
         `TCP_OFS_PERIOD: rd_mux[WIDTH-1:0] = period_q;
         `TCP_OFS_COMPARE: rd_mux[WIDTH-1:0] = compare_q;
         `TCP_OFS_COUNT: rd_mux[WIDTH-1:0] = cnt_q;
         `TCP_OFS_CAPTURE: rd_mux[WIDTH-1:0] = capture_q;
         `TCP_OFS_DEADBAND: rd_mux[DBW-1:0] = dead_q;
         `TCP_OFS_STATUS: rd_mux[3:0] = {kill, cmp_raw, tc_out, run_q};
         `TCP_OFS_PRESCALE: rd_mux[15:0] = prescale_q;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `TCP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- count clock ----------------
   tcp_clk_sel #(
      .FIXDIV(FIXDIV)
   ) u_clk_sel (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(ctrl_q[`TCP_CTRL_CSEL_HI:`TCP_CTRL_CSEL_LO]),
      .prescale(prescale_q),
      .ext_clk_in(ext_clk_in),
      .tick(tick)
   );

   // ---------------- down counter ----------------
   assign at_zero = (cnt_q == {WIDTH{1'b0}});
   assign active = run_q & tick
      & (mode != `TCP_MODE_GATED | gate_en);
   assign tc_evt = active & at_zero;
   assign cap_evt = capture_in & ~cap_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `TCP_RST_PERIOD;
         run_q <= 1'b0;
         cap_q <= 1'b0;
         capture_q <= {WIDTH{1'b0}};
      end else begin
         cap_q <= capture_in;
         if (cap_evt) begin
            capture_q <= cnt_q;
         end
         if (wr_ctrl && !wdata_q[`TCP_CTRL_EN]) begin
            run_q <= 1'b0;
         end else if (start) begin
            run_q <= 1'b1;
         end else if (tc_evt && mode == `TCP_MODE_ONESHOT) begin
            run_q <= 1'b0;
         end
         if (start || timer_rst) begin
            cnt_q <= period_q;
         end else if (tc_evt) begin
            cnt_q <= period_q;
         end else if (active) begin
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // ---------------- comparator and outputs ----------------
   always @* begin
      case (rel)
         `TCP_REL_LESS: cmp_raw = cnt_q < compare_q;
         `TCP_REL_LESS_OR_SAME: cmp_raw = cnt_q <= compare_q;
         `TCP_REL_SAME: cmp_raw = cnt_q == compare_q;
         `TCP_REL_GREATER_OR_SAME: cmp_raw = cnt_q >= compare_q;
         `TCP_REL_GREATER: cmp_raw = cnt_q > compare_q;
         default: cmp_raw = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         cmp_q <= 1'b0;
         compare_out <= 1'b0;
         compare_n_out <= 1'b0;
         tc_out <= 1'b0;
         irq <= 1'b0;
      end else begin
         cmp_q <= cmp_raw;
         compare_out <= cmp_raw & ~kill;
         compare_n_out <= ctrl_q[`TCP_CTRL_CMPN_EN] & ~cmp_raw & ~kill;
         // high from the zero count until the next count tick
         tc_out <= run_q & at_zero & ~start;
         irq <= (tc_evt & ctrl_q[`TCP_CTRL_IE_TC])
            | (cmp_raw & ~cmp_q & ctrl_q[`TCP_CTRL_IE_CMP])
            | (cap_evt & ctrl_q[`TCP_CTRL_IE_CAP]);
      end
   end

   tcp_deadband #(
      .DBW(DBW)
   ) u_deadband (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .level_in(cmp_raw),
      .kill(kill),
      .dead(dead_q),
      .out_hi(pwm_hi),
      .out_lo(pwm_lo)
   );
endmodule // tcp_top

//--- tcp_top_sva.sv
// port assertions for the timer unit
`timescale 1ns/1ps
module tcp_top_chk (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire kill,
   input wire compare_out,
   input wire compare_n_out,
   input wire tc_out,
   input wire pwm_hi,
   input wire pwm_lo,
   input wire irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   kill_cmp_a: assert property (
      kill |=> !compare_out && !compare_n_out)
      else $error("compare output active under kill");
   kill_pwm_a: assert property (
      kill ##1 kill |-> !pwm_hi && !pwm_lo)
      else $error("pwm output active under kill");
   dead_pair_a: assert property (!(pwm_hi && pwm_lo))
      else $error("both pwm outputs high");
   cmp_pair_a: assert property (!(compare_out && compare_n_out))
      else $error("compare and inverse both high");
   irq_pulse_a: assert property (irq |=> !irq)
      else $error("irq longer than one cycle");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   rst_quiet_a: assert property (disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !tc_out)
      else $error("output active after reset");
endmodule // tcp_top_chk
bind tcp_top tcp_top_chk chk (.*);
